// file: hw/scpm_defs.svh
// Constants for the system clock and power mode block
`ifndef SCPM_DEFS_SVH
`define SCPM_DEFS_SVH

// ----------------------------------------------------------------------------
// Control reset values
// ----------------------------------------------------------------------------
`define SCPM_CLKSEL_RST   1'b1
`define SCPM_CKS_RST      3'h0
`define SCPM_IDLE_EN_RST  1'b1
`define SCPM_KEEP_ON_RST  1'b0
`define SCPM_LOWPWR_RST   1'b0

// ----------------------------------------------------------------------------
// System clock source codes (1 = undivided, 1+k = divided by 2**k)
// ----------------------------------------------------------------------------
`define SCPM_SRC_LOW      3'h0
`define SCPM_SRC_HIGH     3'h1
`define SCPM_CKS_LOW_MAX  3'h1
`define SCPM_SRC_COUNT    8
`define SCPM_DIV_STAGES   6

// ----------------------------------------------------------------------------
// Low crystal pin functions
// ----------------------------------------------------------------------------
`define SCPM_PIN_LOW_XTAL  2'h0
`define SCPM_PIN_HIGH_XTAL 2'h1
`define SCPM_PIN_GPIO     2'h2

`endif

// file: hw/scpm_pkg.sv
// Types and decode functions for the system clock and power mode block
`include "scpm_defs.svh"

package scpm_pkg;

    // ------------------------------------------------------------------------
    // Operating modes and halt states
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        SCPM_NORMAL,
        SCPM_SLOW_LOW,
        SCPM_SLOW_DIV,
        SCPM_SLEEP,
        SCPM_IDLE_STOPPED,
        SCPM_IDLE_RUNNING
    } scpm_mode_t;

    typedef enum logic [1:0] {
        SCPM_HS_RUN,
        SCPM_HS_SLEEP,
        SCPM_HS_IDLE_STOP,
        SCPM_HS_IDLE_RUN
    } scpm_halt_t;

    // Select code from the clock select bit and divider field
    function automatic logic [2:0] scpm_src_select(input logic hl, input logic [2:0] cks);
        logic [2:0] res;
        res = `SCPM_SRC_LOW;
        if (hl) begin
            res = `SCPM_SRC_HIGH;
        end else if (cks > `SCPM_CKS_LOW_MAX) begin
            res = 3'(3'h1 - cks);   // 010 -> /64 ... 111 -> /2
        end
        return res;
    endfunction

    // Run mode that a clock selection implies
    function automatic scpm_mode_t scpm_run_mode(input logic [2:0] src);
        scpm_mode_t m;
        m = SCPM_SLOW_DIV;
        if (src == `SCPM_SRC_LOW) begin
            m = SCPM_SLOW_LOW;
        end else if (src == `SCPM_SRC_HIGH) begin
            m = SCPM_NORMAL;
        end
        return m;
    endfunction

endpackage

// file: hw/scpm_clk_div.sv
// Ripple-free divider producing high clock ticks divided by 1 (undivided) to 2**STAGES
`timescale 1ns/10ps
`include "scpm_defs.svh"
module scpm_clk_div import scpm_pkg::*; #(
    parameter int STAGES = `SCPM_DIV_STAGES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              tick,
    output logic [STAGES:0]        div_tick
);

    logic [STAGES-1:0] cnt;
    logic [STAGES-1:0] next_cnt;

    // ------------------------------------------------------------------------
    // Free-running count keeps every divided tick on a full-period boundary
    // ------------------------------------------------------------------------
    always_comb begin
        next_cnt = cnt;
        if (tick) begin
            next_cnt = STAGES'(cnt + 1'b1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= '0;
        end else if (ce) begin
            cnt <= next_cnt;
        end
    end

    // Divided tick fires when all lower count bits are ones
    assign div_tick[0] = tick;
    for (genvar k = 1; k <= STAGES; k++) begin : g_div
        assign div_tick[k] = tick & (&cnt[k-1:0]);
    end

endmodule // scpm_clk_div

// file: hw/scpm_tick_switch.sv
// Glitch-free selector among tick sources
`timescale 1ns/10ps
`include "scpm_defs.svh"
module scpm_tick_switch import scpm_pkg::*; #(
    parameter int N = `SCPM_SRC_COUNT
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic [N-1:0]  tick_vec,
    input  wire logic [2:0]    req_sel,
    input  wire logic          req_ok,
    output logic               tick_out,
    output logic [2:0]         active_sel
);

    typedef enum logic {SCPM_SW_RUN, SCPM_SW_ALIGN} scpm_sw_t;

    scpm_sw_t   state;
    scpm_sw_t   next_state;
    logic [2:0] next_active;

    // ------------------------------------------------------------------------
    // Swap only on an old-source tick, then drop the first new tick so the
    // first forwarded period is a whole period of the new source
    // ------------------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_active = active_sel;
        unique case (state)
            SCPM_SW_RUN: begin
                if (tick_vec[active_sel] && (req_sel != active_sel) && req_ok) begin
                    next_active = req_sel;
                    next_state  = SCPM_SW_ALIGN;
                end
            end
            SCPM_SW_ALIGN: begin
                if (tick_vec[active_sel]) begin
                    next_state = SCPM_SW_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= SCPM_SW_RUN;
            active_sel <= `SCPM_SRC_HIGH;
        end else if (ce) begin
            state      <= next_state;
            active_sel <= next_active;
        end
    end

    assign tick_out = ce && (state == SCPM_SW_RUN) && tick_vec[active_sel];

endmodule // scpm_tick_switch

// file: hw/scpm_clock_power.sv
// Clock source selection and operating mode control, top level
//
// Functional notes
// R1 - Low crystal runs quick start when power save bit is 0, low power at 1.
// R2 - Power save bit clears at reset so the low crystal starts quickly.
// R3 - Software should set power save about two seconds after power on.
// R4 - Low crystal ticks are never gated by the power save bit.
// R5 - High clock comes from crystal or RC oscillator, fixed by configuration.
// R6 - Low clock comes from crystal or RC oscillator, fixed by configuration.
// R7 - System clock is high, divided high or low clock by select bits.
// R8 - Substitute and time-base clocks come from the configured low source.
// R9 - Substitute clock feeds watchdog and wake clock; time-base feeds timers.
// R10 - Switching to low clock stops the high oscillator and its divided ticks.
// R11 - Six modes: three with CPU running, three with CPU stopped.
// R12 - Normal mode clocks CPU from high clock; substitute and time-base run.
// R13 - Slow low mode uses low clock, high oscillator off, side clocks run.
// R14 - Slow divided mode uses high clock divided by 2 to 64.
// R15 - Halt with idle disabled enters sleep; only substitute clock runs.
// R16 - Halt idle, keep-on low: system oscillator stops, side clocks run.
// R17 - Halt idle, keep-on high: CPU stops, system and substitute clocks run.
// R18 - Configuration sets low crystal pins to low crystal, high crystal or I/O.
// R19 - Divider codes 000/001 give low clock; 010..111 give high/64 .. high/2.
// R20 - Clock select bit 1 picks undivided high clock; 0 uses divider field.
// R21 - Source and ratio changes never produce runt ticks.
// R22 - Wake-up resumes the run mode given by the clock selection.
`timescale 1ns/10ps
`include "scpm_defs.svh"
module scpm_clock_power import scpm_pkg::*; (
    input  wire logic              MCLK,
    input  wire logic              SYS_RST,
    input  wire logic              CLK_EN,
    input  wire logic              CFG_HIGH_SRC_RC,
    input  wire logic              CFG_LOW_SRC_RC,
    input  wire logic              HIGH_XTAL_TICK,
    input  wire logic              HIGH_RC_TICK,
    input  wire logic              LOW_XTAL_TICK,
    input  wire logic              LOW_RC_TICK,
    input  wire logic              HIGH_OSC_READY,
    input  wire logic              CTRL_WE,
    input  wire logic              LXT_POWER_SAVE_SELECT,
    input  wire logic              HIGH_LOW_CLOCK_SELECT,
    input  wire logic [2:0]        SYS_CLOCK_DIVIDER_SELECT,
    input  wire logic              IDLE_ON_HALT_ENABLE,
    input  wire logic              IDLE_SYSCLK_KEEP_ON,
    input  wire logic              POWER_DOWN_INSTRUCTION,
    input  wire logic              WAKE_UP,
    output scpm_mode_t             MODE,
    output logic                   LXT_LOW_POWER,
    output logic                   HIGH_OSC_ON,
    output logic [2:0]             SYS_SRC_ACTIVE,
    output logic [1:0]             XT_PIN_FUNC,
    output logic                   CPU_CLK_EN,
    output logic                   SYS_CLK_EN,
    output logic                   SUB_CLK_EN,
    output logic                   TIMEBASE_CLK_EN,
    output logic                   HIGH_CLK_EN
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    logic        clk_sel_high;
    logic [2:0]  cks;
    logic        idle_en;
    logic        keep_on;
    logic        next_clk_sel_high;
    logic [2:0]  next_cks;
    logic        next_idle_en;
    logic        next_keep_on;
    logic        next_lxt_low_power;
    logic        cfg_high_rc;
    logic        cfg_low_rc;
    logic [1:0]  next_pin_func;
    scpm_halt_t  halt;
    scpm_halt_t  next_halt;
    scpm_mode_t  next_mode;
    logic        high_tick;
    logic        low_tick;
    logic        sys_tick;
    logic        run;
    logic [2:0]  req_sel;
    logic        req_ok;
    logic        high_needed;
    logic [`SCPM_DIV_STAGES:0] div_tick;
    logic [`SCPM_SRC_COUNT-1:0] src_ticks;

    // ------------------------------------------------------------------------
    // Control bits; reset values put the part in normal, idle-on-halt mode
    // ------------------------------------------------------------------------
    always_comb begin
        next_clk_sel_high  = clk_sel_high;
        next_cks           = cks;
        next_idle_en       = idle_en;
        next_keep_on       = keep_on;
        next_lxt_low_power = LXT_LOW_POWER;
        if (CTRL_WE) begin
            next_clk_sel_high  = HIGH_LOW_CLOCK_SELECT;
            next_cks           = SYS_CLOCK_DIVIDER_SELECT;
            next_idle_en       = IDLE_ON_HALT_ENABLE;
            next_keep_on       = IDLE_SYSCLK_KEEP_ON;
            next_lxt_low_power = LXT_POWER_SAVE_SELECT;   // R1
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            clk_sel_high  <= `SCPM_CLKSEL_RST;
            cks           <= `SCPM_CKS_RST;
            idle_en       <= `SCPM_IDLE_EN_RST;
            keep_on       <= `SCPM_KEEP_ON_RST;
            LXT_LOW_POWER <= `SCPM_LOWPWR_RST;             // R2
        end else if (CLK_EN) begin
            clk_sel_high  <= next_clk_sel_high;
            cks           <= next_cks;
            idle_en       <= next_idle_en;
            keep_on       <= next_keep_on;
            LXT_LOW_POWER <= next_lxt_low_power;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration straps are sampled while reset is held, so the oscillator
    // choice cannot move under a running program
    // ------------------------------------------------------------------------
    always_comb begin
        if (!CFG_LOW_SRC_RC) begin
            next_pin_func = `SCPM_PIN_LOW_XTAL;            // R18
        end else if (!CFG_HIGH_SRC_RC) begin
            next_pin_func = `SCPM_PIN_HIGH_XTAL;           // R18
        end else begin
            next_pin_func = `SCPM_PIN_GPIO;                // R18
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            cfg_high_rc <= CFG_HIGH_SRC_RC;
            cfg_low_rc  <= CFG_LOW_SRC_RC;
            XT_PIN_FUNC <= next_pin_func;
        end
    end

    // ------------------------------------------------------------------------
    // Oscillator sources
    // ------------------------------------------------------------------------
    assign high_tick = cfg_high_rc ? HIGH_RC_TICK : HIGH_XTAL_TICK;            // R5
    assign low_tick  = CLK_EN && (cfg_low_rc ? LOW_RC_TICK : LOW_XTAL_TICK);   // R6

    // Substitute clock for watchdog and wake; never depends on power save
    assign SUB_CLK_EN = low_tick;                                       // R4 R8 R9

    // Time-base clock for time-base and timers, off only in sleep
    assign TIMEBASE_CLK_EN = low_tick && (halt != SCPM_HS_SLEEP);       // R8 R9 R15

    // ------------------------------------------------------------------------
    // System clock selection and glitch-free switch
    // ------------------------------------------------------------------------
    assign req_sel   = scpm_src_select(clk_sel_high, cks);              // R7 R19 R20
    // High sources are entered only once the oscillator has settled
    assign req_ok    = (req_sel == `SCPM_SRC_LOW) || HIGH_OSC_READY;
    assign src_ticks = {div_tick, low_tick};

    scpm_clk_div #(
        .STAGES   (`SCPM_DIV_STAGES)
    ) u_div (
        .clk      (MCLK),
        .rst      (SYS_RST),
        .ce       (CLK_EN),
        .tick     (high_tick && HIGH_OSC_ON),
        .div_tick (div_tick)
    );                                                                  // R14

    scpm_tick_switch #(
        .N          (`SCPM_SRC_COUNT)
    ) u_switch (
        .clk        (MCLK),
        .rst        (SYS_RST),
        .ce         (CLK_EN),
        .tick_vec   (src_ticks),
        .req_sel    (req_sel),
        .req_ok     (req_ok),
        .tick_out   (sys_tick),
        .active_sel (SYS_SRC_ACTIVE)
    );                                                                  // R21

    // ------------------------------------------------------------------------
    // Halt state: entry by the power-down instruction, exit by wake-up
    // ------------------------------------------------------------------------
    always_comb begin
        next_halt = halt;
        unique case (halt)
            SCPM_HS_RUN: begin
                if (POWER_DOWN_INSTRUCTION) begin
                    if (!idle_en) begin
                        next_halt = SCPM_HS_SLEEP;                      // R15
                    end else if (!keep_on) begin
                        next_halt = SCPM_HS_IDLE_STOP;                  // R16
                    end else begin
                        next_halt = SCPM_HS_IDLE_RUN;                   // R17
                    end
                end
            end
            SCPM_HS_SLEEP, SCPM_HS_IDLE_STOP, SCPM_HS_IDLE_RUN: begin
                if (WAKE_UP) begin
                    next_halt = SCPM_HS_RUN;                            // R22
                end
            end
        endcase
    end

    // Mode reported from the halt state and the current selection
    always_comb begin
        unique case (next_halt)
            SCPM_HS_SLEEP: next_mode = SCPM_SLEEP;
            SCPM_HS_IDLE_STOP: next_mode = SCPM_IDLE_STOPPED;
            SCPM_HS_IDLE_RUN:  next_mode = SCPM_IDLE_RUNNING;
            SCPM_HS_RUN:       next_mode = scpm_run_mode(scpm_src_select(next_clk_sel_high, next_cks)); // R11 R22
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            halt <= SCPM_HS_RUN;
            MODE <= SCPM_NORMAL;
        end else if (CLK_EN) begin
            halt <= next_halt;
            MODE <= next_mode;
        end
    end

    // ------------------------------------------------------------------------
    // Clock gating
    // ------------------------------------------------------------------------
    assign run = (halt == SCPM_HS_RUN);

    // High oscillator runs while a run mode needs it or idle-running keeps it;
    // the switch keeps it alive until it has left the high source
    assign high_needed = (SYS_SRC_ACTIVE != `SCPM_SRC_LOW) || (req_sel != `SCPM_SRC_LOW);
    assign HIGH_OSC_ON = (run && high_needed) ||
                         ((halt == SCPM_HS_IDLE_RUN) && (SYS_SRC_ACTIVE != `SCPM_SRC_LOW)); // R10 R13 R16

    // Peripheral high clock disappears with the oscillator
    assign HIGH_CLK_EN = CLK_EN && high_tick && HIGH_OSC_ON;            // R10

    assign CPU_CLK_EN = sys_tick && run;                                // R12 R13 R14
    assign SYS_CLK_EN = sys_tick && (run || (halt == SCPM_HS_IDLE_RUN)); // R15 R16 R17

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking scpm_cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    lxt_lowpower_set_a: assert property (CLK_EN && CTRL_WE && LXT_POWER_SAVE_SELECT |=> LXT_LOW_POWER) // R1
        else $error("Low power select not taken");
    por_quick_a: assert property ($past(SYS_RST) |-> !LXT_LOW_POWER) // R2
        else $error("Low crystal not in quick start after reset");
    sub_ungated_a: assert property (SUB_CLK_EN == (CLK_EN && (cfg_low_rc ? LOW_RC_TICK : LOW_XTAL_TICK))) // R4
        else $error("Substitute clock gated");
    high_source_a: assert property (HIGH_CLK_EN |-> (cfg_high_rc ? HIGH_RC_TICK : HIGH_XTAL_TICK)) // R5
        else $error("High clock from wrong source");
    slow_osc_off_a: assert property (run && (SYS_SRC_ACTIVE == `SCPM_SRC_LOW) && (req_sel == `SCPM_SRC_LOW)
                                     |-> !HIGH_OSC_ON && !HIGH_CLK_EN) // R10
        else $error("High oscillator left running on low clock");
    sleep_clocks_a: assert property ((halt == SCPM_HS_SLEEP) |-> !CPU_CLK_EN && !SYS_CLK_EN && !TIMEBASE_CLK_EN) // R15
        else $error("Clock running in sleep");
    idle_stopped_a: assert property ((halt == SCPM_HS_IDLE_STOP) |-> !SYS_CLK_EN && !HIGH_OSC_ON &&
                                     (TIMEBASE_CLK_EN == SUB_CLK_EN)) // R16
        else $error("Idle stopped clocks wrong");
    idle_running_a: assert property ((halt == SCPM_HS_IDLE_RUN) && sys_tick |-> SYS_CLK_EN && !CPU_CLK_EN) // R17
        else $error("Idle running clocks wrong");
    halt_entry_a: assert property (CLK_EN && run && POWER_DOWN_INSTRUCTION && !idle_en
                                   |=> MODE == SCPM_SLEEP ##1 MODE == SCPM_SLEEP || $past(WAKE_UP)) // R11
        else $error("Sleep not entered on halt");
    wake_resume_a: assert property (CLK_EN && !run && WAKE_UP && !CTRL_WE
                                    |=> MODE == scpm_run_mode(req_sel)) // R22
        else $error("Wake-up resumed in wrong mode");
    pin_func_a: assert property (!cfg_low_rc |-> XT_PIN_FUNC == `SCPM_PIN_LOW_XTAL) // R18
        else $error("Low crystal pins not given to the crystal");
    no_runt_a: assert property ($changed(SYS_SRC_ACTIVE) |-> !sys_tick) // R21
        else $error("Tick forwarded during source change");
    // A tick of the held source a cycle ago ends any alignment, so forwarding is then exact
    low_steady_a: assert property ((SYS_SRC_ACTIVE == `SCPM_SRC_LOW) && $past(SYS_SRC_ACTIVE) == `SCPM_SRC_LOW
                                   && $past(low_tick)
                                   |-> sys_tick == low_tick) // R19
        else $error("Low clock not forwarded");
    high_steady_a: assert property ((SYS_SRC_ACTIVE == `SCPM_SRC_HIGH) && $past(SYS_SRC_ACTIVE) == `SCPM_SRC_HIGH
                                    && $past(HIGH_CLK_EN) && HIGH_OSC_ON
                                    |-> sys_tick == HIGH_CLK_EN) // R20
        else $error("Undivided high clock not forwarded");

    sleep_entry_c: cover property (run ##1 (halt == SCPM_HS_SLEEP));
    idle_run_c:    cover property ((halt == SCPM_HS_IDLE_RUN) && SYS_CLK_EN);
    slow_div_c:    cover property ((MODE == SCPM_SLOW_DIV) && CPU_CLK_EN);
    wake_c:        cover property ((halt == SCPM_HS_IDLE_STOP) ##1 run);

endmodule // scpm_clock_power

// file: test/scpm_testbench.sv
// Self-checking testbench for the system clock and power mode block
`timescale 1ns/10ps
`include "scpm_defs.svh"
module testbench;
    import scpm_pkg::*;
    typedef struct {int when; int idx; logic [2:0] val;} scpm_note_t;
    logic       mclk, rst, cfg_hrc, cfg_lrc, hi_x, hi_rc, lo_x, lo_rc, we, lp, hl, idle, keep, pd, wk;
    logic [2:0] cks;
    scpm_mode_t mode;
    logic       lxt_lp, hosc_on, cpu_en, sys_en, sub_en, tb_en, hclk_en;
    logic [2:0] src;
    logic [1:0] xt_func;
    scpm_note_t note_q[$];
    int         cyc, n_mismatch, n_tests;
    string      names[10] = '{"MODE", "LXT_LOW_POWER", "SYS_SRC_ACTIVE", "HIGH_OSC_ON", "CPU_CLK_EN",
                              "TIMEBASE_CLK_EN", "SUB_CLK_EN", "SYS_CLK_EN", "XT_PIN_FUNC", "HIGH_CLK_EN"};

    // Run enable and oscillator ready held fixed; both source straps are random
    scpm_clock_power u_dut (
        .MCLK(mclk), .SYS_RST(rst), .CLK_EN(1'b1), .CFG_HIGH_SRC_RC(cfg_hrc), .CFG_LOW_SRC_RC(cfg_lrc),
        .HIGH_XTAL_TICK(hi_x), .HIGH_RC_TICK(hi_rc), .LOW_XTAL_TICK(lo_x), .LOW_RC_TICK(lo_rc),
        .HIGH_OSC_READY(1'b1),
        .CTRL_WE(we), .LXT_POWER_SAVE_SELECT(lp), .HIGH_LOW_CLOCK_SELECT(hl), .SYS_CLOCK_DIVIDER_SELECT(cks),
        .IDLE_ON_HALT_ENABLE(idle), .IDLE_SYSCLK_KEEP_ON(keep), .POWER_DOWN_INSTRUCTION(pd), .WAKE_UP(wk),
        .MODE(mode), .LXT_LOW_POWER(lxt_lp), .HIGH_OSC_ON(hosc_on), .SYS_SRC_ACTIVE(src),
        .XT_PIN_FUNC(xt_func), .CPU_CLK_EN(cpu_en), .SYS_CLK_EN(sys_en), .SUB_CLK_EN(sub_en),
        .TIMEBASE_CLK_EN(tb_en), .HIGH_CLK_EN(hclk_en)
    );

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ------------------------------------------------------------------------
    // Scoreboard: notes are checked a quarter cycle after the driving edge
    // ------------------------------------------------------------------------
    function automatic logic [2:0] pick(int i);
        case (i)
            0:       return mode;
            1:       return {2'h0, lxt_lp};
            2:       return src;
            3:       return {2'h0, hosc_on};
            4:       return {2'h0, cpu_en};
            5:       return {2'h0, tb_en};
            6:       return {2'h0, sub_en};
            7:       return {2'h0, sys_en};
            8:       return {1'b0, xt_func};
            default: return {2'h0, hclk_en};
        endcase
    endfunction

    task automatic check(string nm, logic [2:0] seen, logic [2:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    always @(negedge mclk) begin
        #5;
        while (note_q.size() > 0 && note_q[0].when <= cyc) begin
            check(names[note_q[0].idx], pick(note_q[0].idx), note_q[0].val);
            void'(note_q.pop_front());
        end
    end

    task automatic note(int idx, logic [2:0] v, int d);
        note_q.push_back('{cyc + d, idx, v});
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Drivers: step and ctl take one falling edge each, random oscillator ticks
    // ------------------------------------------------------------------------
    task automatic step(logic w, logic p, logic k);
        @(negedge mclk);
        hi_x = 1'($urandom % 2);
        hi_rc = 1'($urandom % 2);
        lo_x = ($urandom % 4) == 0;
        lo_rc = ($urandom % 4) == 0;
        we = w;
        pd = p;
        wk = k;
        cyc++;
    endtask

    // Random power save bit rides along on every control write
    task automatic ctl(logic h, logic [2:0] c, logic i, logic k);
        step(1'b1, 1'b0, 1'b0);
        hl = h;
        cks = c;
        idle = i;
        keep = k;
        lp = 1'($urandom % 2);
        note(1, {2'h0, lp}, 1);
    endtask

    // Switch completes on a tick of the old source, so the wait is bounded, not fixed
    task automatic wait_src(logic [2:0] es);
        int i;
        for (i = 0; i < 600 && src !== es; i++) step(1'b0, 1'b0, 1'b0);
        if (i == 600) begin
            n_mismatch++;
            $display("wrong value SYS_SRC_ACTIVE expected %h seen %h", es, src);
            give_verdict();
        end
        step(1'b0, 1'b0, 1'b0);
        note(2, es, 0);
        note(3, {2'h0, es != 3'h0}, 0);
        note(9, {2'h0, (cfg_hrc ? hi_rc : hi_x) & (es != 3'h0)}, 0);
    endtask

    task automatic halt_case(int m, logic [2:0] rm, logic [2:0] es);
        logic [2:0] hm;
        hm = (m == 0) ? SCPM_SLEEP : ((m == 1) ? SCPM_IDLE_STOPPED : SCPM_IDLE_RUNNING);
        ctl(hl, cks, m != 0, m == 2);
        step(1'b0, 1'b1, 1'b0);
        step(1'b0, 1'b0, 1'b0);
        note(0, hm, 0);
        note(4, 3'h0, 0);
        note(5, {2'h0, (cfg_lrc ? lo_rc : lo_x) & (m != 0)}, 0);
        note(6, {2'h0, (cfg_lrc ? lo_rc : lo_x)}, 0);
        note(3, {2'h0, (m == 2) & (es != 3'h0)}, 0);
        step(1'b0, 1'b0, 1'b1);
        note(0, rm, 1);
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        logic       h;
        logic [2:0] rm;
        logic [2:0] es;
        void'($urandom(37382));
        {hi_x, hi_rc, lo_x, lo_rc, we, lp, idle, keep, pd, wk} = '0;
        {hl, cks, rst, cyc, n_mismatch, n_tests} = {1'b1, 3'h0, 1'b1, 96'h0};
        cfg_hrc = 1'($urandom % 2);
        cfg_lrc = 1'($urandom % 2);
        repeat (10) step(1'b0, 1'b0, 1'b0);
        rst = 1'b0;
        step(1'b0, 1'b0, 1'b0);
        note(0, SCPM_NORMAL, 0);
        note(1, 3'h0, 0);
        note(2, `SCPM_SRC_HIGH, 0);
        note(8, {1'b0, cfg_lrc ? (cfg_hrc ? `SCPM_PIN_GPIO : `SCPM_PIN_HIGH_XTAL) : `SCPM_PIN_LOW_XTAL}, 0);
        // Every divider code, then back to the undivided high clock
        for (int c = 0; c < 9; c++) begin
            h = (c == 8);
            ctl(h, c[2:0], 1'b0, 1'b0);
            rm = h ? SCPM_NORMAL : ((c < 2) ? SCPM_SLOW_LOW : SCPM_SLOW_DIV);
            es = h ? 3'h1 : ((c < 2) ? 3'h0 : 3'(9 - c));
            note(0, rm, 1);
            wait_src(es);
            for (int m = 0; m < 3; m++) halt_case(m, rm, es);
        end
        repeat (2) step(1'b0, 1'b0, 1'b0);
        give_verdict();
    end
endmodule // testbench
